// ---- hw/lbaf_params.svh ----
// constants of the lin receive block: offsets, fields, resets, counts
// assumes a 32-bit axi4-lite slave with byte addresses
`ifndef LBAF_PARAMS_SVH
`define LBAF_PARAMS_SVH
// register byte offsets
`define LBAF_A_CTRL0 6'h00
`define LBAF_A_MODESTAT 6'h04
`define LBAF_A_CTRL1 6'h08
`define LBAF_A_STAT0 6'h0c
`define LBAF_A_BAUD 6'h10
`define LBAF_A_RXDATA 6'h14
// banks behind ctrl1 / stat0
`define LBAF_BANK_MP 3'h0
`define LBAF_BANK_NF 3'h1
`define LBAF_BANK_LIN 3'h2
// link states
`define LBAF_LS_SLEEP 2'h0
`define LBAF_LS_WAIT 2'h1
`define LBAF_LS_ABAUD 2'h2
`define LBAF_LS_ACTIVE 2'h3
// status bit positions
`define LBAF_ST_RDY 0
`define LBAF_ST_OE 1
`define LBAF_ST_NE 2
`define LBAF_ST_WAKE 3
`define LBAF_ST_BRK 4
`define LBAF_ST_ABOV 5
`define LBAF_ST_ADR 6
// counts in bit times and clocks
`define LBAF_WAKE_BITS 4'h3
`define LBAF_BRK_BITS 4'hb
`define LBAF_BRK_SAT 4'hf
`define LBAF_AB_PRE_LAST 3'h7
`define LBAF_AB_EDGES 3'h5
`define LBAF_FLT_MINW 4'h4
// reset values, synch preload and bus response codes
`define LBAF_BAUD_RST 16'h0010
`define LBAF_FCNT_RST 11'h00f
`define LBAF_SYNC_PRE 8'haa
`define LBAF_RESP_OK 2'h0
`define LBAF_RESP_ERR 2'h2
`endif

// ---- hw/lbaf_pkg.sv ----
// types of the lin receive block
// assumes nothing beyond the params header
package lbaf_pkg;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_ADDR, RX_STOP} lbaf_rx_t;
  typedef struct packed {
    logic linMasterSelect;
    logic linSlaveSelect;
    logic autobaudLoadEnable;
    logic [1:0] linLinkState;
  } lbaf_lin_t;
  typedef struct packed {
    logic awOk, wOk, bvalid, rvalid;
    logic [5:0] awAddr;
    logic [31:0] wData;
    logic [1:0] wStrb, bresp, rresp;
    logic [31:0] rdata;
    logic rxEn, mpMode;
    logic [2:0] bank, nfSel;
    lbaf_lin_t lin;
    logic [15:0] baud;
    logic rdy, oe, ne, wake, brk, abOvr, adr;
    logic [7:0] rxData;
    logic in1, filt, rxF, rxFd;
    logic [10:0] fcnt;
    lbaf_rx_t rst;
    logic [15:0] btim;
    logic [3:0] bidx;
    logic [7:0] shift;
    logic rxAdrBit, noisy;
    logic [15:0] lowCyc, abCnt;
    logic [3:0] lowBits, brkLen;
    logic [2:0] pre, abEdges;
  } lbaf_state_t;
endpackage : lbaf_pkg

// ---- hw/lbaf_uart.sv ----
// lin receive path: noise filter, 9-bit receiver, break/wake timing, autobaud
// assumes rxd synchronous to clk and an axi4-lite master on the register port
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "lbaf_params.svh"

// Behaviour
// - in multiprocessor mode an address flag bit follows data bits, before stop.
// - while the cpu is stopped nothing is detected or timed here except by the noise filter, which keeps running.
// - enabled, running and in link state sleep, low pulses of 3 bit times or more flag wake-up.
// - break length readable in bit times, four bits, saturating at fh.
// - software writing link state 00 selects sleep; hardware never enters sleep.
// - slave mode is master select 0, slave select 1, link state 01.
// - in wait-for-break a low of 11 bit times flags break; shorter does not.
// - after a valid break hardware enters autobaud and times the synch character.
// - autobaud counter steps every 8th clock from start bit to bit 7.
// - measured count goes to the baud divider only with autobaud load enable.
// - autobaud counter overflow flags overrun and leaves the divider unchanged.
// - noise filter is a saturating up/down counter, 4 to 11 bits wide.
// - filter output falls on stepping into zeros, rises on stepping into ones.
// - the filter delays the received stream by three clocks.
// - unsaturated indicator seen at a bit centre sets the noise error flag.
// - ctrl1 and stat0 accesses reach the bank chosen by the bank select.
module lbaf_uart import lbaf_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rxd,
  input wire logic cpuStopped,
  output logic rxFiltered,
  output logic [1:0] linLinkState
);
  lbaf_state_t s_r, s_nxt;
  logic active, fall, rise, linSlave, rxOn, unsat, doWr, tick, abStep;
  logic [10:0] maxv;
  logic [15:0] per, pm1, half, abVal, lowBase;
  logic [3:0] bitsBase;
  logic [31:0] rd;

  assign active = s_r.rxEn && !cpuStopped;
  assign fall = s_r.rxFd && !s_r.rxF;
  assign rise = !s_r.rxFd && s_r.rxF;
  assign linSlave = !s_r.lin.linMasterSelect && s_r.lin.linSlaveSelect;
  assign rxOn = active && !(linSlave && s_r.lin.linLinkState[1] != s_r.lin.linLinkState[0]);
  assign maxv = 11'((11'h1 << (4'(s_r.nfSel) + `LBAF_FLT_MINW)) - 11'h1);
  assign unsat = s_r.fcnt != 11'h0 && s_r.fcnt != maxv;
  // a zero divider would never tick, so it runs as one
  assign per = (s_r.baud == 16'h0) ? 16'h1 : s_r.baud;
  assign pm1 = per - 16'h1;
  assign half = per >> 1;
  assign doWr = s_r.awOk && s_r.wOk && !s_r.bvalid;
  assign tick = s_r.btim == pm1;
  assign abStep = s_r.pre == `LBAF_AB_PRE_LAST;
  // the step that lands on the closing edge still belongs to the period
  assign abVal = abStep ? s_r.abCnt + 16'h1 : s_r.abCnt;
  // the falling-edge clock is the first low clock, so n periods count n
  assign lowBase = fall ? 16'h0 : s_r.lowCyc;
  assign bitsBase = fall ? 4'h0 : s_r.lowBits;

  assign s_axi_awready = !s_r.awOk;
  assign s_axi_wready = !s_r.wOk;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign rxFiltered = s_r.rxF;
  assign linLinkState = s_r.lin.linLinkState;

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    rd = 32'h0;
    case (s_axi_araddr)
      `LBAF_A_CTRL0: rd[0] = s_r.rxEn;
      `LBAF_A_MODESTAT: rd[7:0] = {s_r.brkLen, 1'b0, s_r.bank};
      `LBAF_A_CTRL1: begin
        case (s_r.bank)
          `LBAF_BANK_MP: rd[0] = s_r.mpMode;
          `LBAF_BANK_NF: rd[2:0] = s_r.nfSel;
          `LBAF_BANK_LIN: rd[4:0] = s_r.lin;
          default: rd = 32'h0;
        endcase
      end
      `LBAF_A_STAT0: begin
        case (s_r.bank)
          `LBAF_BANK_MP: rd[6:0] = {s_r.adr, s_r.abOvr, s_r.brk, s_r.wake, s_r.ne, s_r.oe, s_r.rdy};
          `LBAF_BANK_LIN: rd[6:0] = {unsat, s_r.lin.linLinkState, s_r.brkLen};
          default: rd = 32'h0;
        endcase
      end
      `LBAF_A_BAUD: rd[15:0] = s_r.baud;
      `LBAF_A_RXDATA: rd[8:0] = {s_r.adr, s_r.rxData};
      default: rd = 32'h0;
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    // bus slave: address and data taken in either order
    if (s_axi_awvalid && !s_r.awOk) begin
      s_nxt.awOk = 1'b1;
      s_nxt.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_r.wOk) begin
      s_nxt.wOk = 1'b1;
      s_nxt.wData = s_axi_wdata;
      s_nxt.wStrb = s_axi_wstrb[1:0];
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (doWr) begin
      s_nxt.awOk = 1'b0;
      s_nxt.wOk = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = (s_r.awAddr > `LBAF_A_RXDATA || s_r.awAddr[1:0] != 2'h0) ? `LBAF_RESP_ERR : `LBAF_RESP_OK;
      if (s_r.wStrb[0]) begin
        case (s_r.awAddr)
          `LBAF_A_CTRL0: s_nxt.rxEn = s_r.wData[0];
          `LBAF_A_MODESTAT: s_nxt.bank = s_r.wData[2:0];
          `LBAF_A_CTRL1: begin
            case (s_r.bank)
              `LBAF_BANK_MP: s_nxt.mpMode = s_r.wData[0];
              `LBAF_BANK_NF: s_nxt.nfSel = s_r.wData[2:0];
              `LBAF_BANK_LIN: s_nxt.lin = s_r.wData[4:0];
              default: s_nxt.lin = s_r.lin;
            endcase
          end
          `LBAF_A_STAT0: begin
            if (s_r.bank == `LBAF_BANK_MP) begin
              s_nxt.oe = s_r.oe && !s_r.wData[`LBAF_ST_OE];
              s_nxt.ne = s_r.ne && !s_r.wData[`LBAF_ST_NE];
              s_nxt.wake = s_r.wake && !s_r.wData[`LBAF_ST_WAKE];
              s_nxt.brk = s_r.brk && !s_r.wData[`LBAF_ST_BRK];
              s_nxt.abOvr = s_r.abOvr && !s_r.wData[`LBAF_ST_ABOV];
            end
          end
          `LBAF_A_BAUD: s_nxt.baud[7:0] = s_r.wData[7:0];
          default: s_nxt.rxEn = s_r.rxEn;
        endcase
      end
      if (s_r.wStrb[1] && s_r.awAddr == `LBAF_A_BAUD) begin
        s_nxt.baud[15:8] = s_r.wData[15:8];
      end
    end
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_r.rvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd;
      s_nxt.rresp = (s_axi_araddr > `LBAF_A_RXDATA || s_axi_araddr[1:0] != 2'h0) ? `LBAF_RESP_ERR : `LBAF_RESP_OK;
      // reading the data word frees the holding register
      if (s_axi_araddr == `LBAF_A_RXDATA) begin
        s_nxt.rdy = 1'b0;
      end
    end

    // noise filter; hardware sets below win over the clears above
    s_nxt.in1 = rxd;
    if (s_r.fcnt > maxv) begin
      s_nxt.fcnt = maxv;
    end else if (s_r.in1 && s_r.fcnt != maxv) begin
      s_nxt.fcnt = s_r.fcnt + 11'h1;
    end else if (!s_r.in1 && s_r.fcnt != 11'h0) begin
      s_nxt.fcnt = s_r.fcnt - 11'h1;
    end
    if (s_r.in1 && s_nxt.fcnt == maxv && s_r.fcnt != maxv) begin
      s_nxt.filt = 1'b1;
    end
    if (!s_r.in1 && s_nxt.fcnt == 11'h0 && s_r.fcnt != 11'h0) begin
      s_nxt.filt = 1'b0;
    end
    s_nxt.rxF = s_r.filt; // third clock of delay
    s_nxt.rxFd = s_r.rxF;

    // low-time measurement in bit periods
    if (!active) begin
      s_nxt.lowCyc = 16'h0;
      s_nxt.lowBits = 4'h0;
    end else if (!s_r.rxF) begin
      s_nxt.lowCyc = (lowBase == pm1) ? 16'h0 : lowBase + 16'h1;
      s_nxt.lowBits = bitsBase;
      if (lowBase == pm1 && bitsBase != `LBAF_BRK_SAT) begin
        s_nxt.lowBits = bitsBase + 4'h1;
      end
    end
    // ordinary zero bits stay below the wake length, so they leave the count alone
    if (active && rise && s_r.lowBits >= `LBAF_WAKE_BITS) begin
      s_nxt.brkLen = s_r.lowBits;
      if (s_r.lin.linLinkState == `LBAF_LS_SLEEP) begin
        s_nxt.wake = 1'b1;
      end
      if (linSlave && s_r.lin.linLinkState == `LBAF_LS_WAIT && s_r.lowBits >= `LBAF_BRK_BITS) begin
        s_nxt.brk = 1'b1;
        s_nxt.lin.linLinkState = `LBAF_LS_ABAUD;
        s_nxt.abEdges = 3'h0;
      end
    end

    // receiver, sampling at bit centres
    case (s_r.rst)
      RX_IDLE: begin
        if (fall) begin
          s_nxt.rst = RX_START;
          s_nxt.btim = 16'h0;
          s_nxt.noisy = 1'b0;
        end
      end
      RX_START: begin
        s_nxt.btim = s_r.btim + 16'h1;
        if (s_r.btim == half) begin
          s_nxt.rst = s_r.rxF ? RX_IDLE : RX_DATA;
          s_nxt.btim = 16'h0;
          s_nxt.bidx = 4'h0;
          s_nxt.noisy = unsat;
        end
      end
      RX_DATA, RX_ADDR, RX_STOP: begin
        s_nxt.btim = tick ? 16'h0 : s_r.btim + 16'h1;
        if (tick) begin
          s_nxt.noisy = s_r.noisy || unsat;
          if (s_r.rst == RX_DATA) begin
            s_nxt.shift = {s_r.rxF, s_r.shift[7:1]};
            s_nxt.bidx = s_r.bidx + 4'h1;
            if (s_r.bidx == 4'h7) begin
              s_nxt.rst = s_r.mpMode ? RX_ADDR : RX_STOP;
            end
          end else if (s_r.rst == RX_ADDR) begin
            s_nxt.rxAdrBit = s_r.rxF;
            s_nxt.rst = RX_STOP;
          end else begin
            s_nxt.rst = RX_IDLE;
            s_nxt.rxData = s_r.shift;
            s_nxt.adr = s_r.mpMode && s_r.rxAdrBit;
            s_nxt.rdy = 1'b1;
            // built on the next value so a same-cycle clear is kept when nothing new sets
            s_nxt.oe = s_nxt.oe || s_r.rdy;
            s_nxt.ne = s_nxt.ne || s_r.noisy || unsat;
          end
        end
      end
      default: s_nxt.rst = RX_IDLE;
    endcase
    if (!rxOn) begin
      s_nxt.rst = RX_IDLE;
    end

    // autobaud over the synch character
    if (active && s_r.lin.linLinkState == `LBAF_LS_ABAUD) begin
      if (s_r.abEdges == 3'h0) begin
        if (fall) begin
          s_nxt.abEdges = 3'h1;
          s_nxt.pre = 3'h0;
          s_nxt.abCnt = 16'h0;
        end
      end else begin
        s_nxt.pre = s_r.pre + 3'h1;
        if (abStep) begin
          s_nxt.abCnt = s_r.abCnt + 16'h1;
        end
        if (abStep && s_r.abCnt == 16'hffff) begin
          s_nxt.abOvr = 1'b1;
          s_nxt.oe = 1'b1;
          s_nxt.abEdges = 3'h0;
          s_nxt.lin.linLinkState = `LBAF_LS_ACTIVE;
        end else if (fall && s_r.abEdges + 3'h1 == `LBAF_AB_EDGES) begin
          // fifth falling edge is the start of bit 7
          s_nxt.abEdges = 3'h0;
          s_nxt.lin.linLinkState = `LBAF_LS_ACTIVE;
          if (s_r.lin.autobaudLoadEnable) begin
            s_nxt.baud = abVal;
          end
          s_nxt.rst = RX_DATA;
          s_nxt.bidx = 4'h7;
          s_nxt.shift = `LBAF_SYNC_PRE;
          s_nxt.noisy = 1'b0;
          s_nxt.btim = (s_r.lin.autobaudLoadEnable && abVal != 16'h0) ? abVal >> 1 : half;
        end else if (fall) begin
          s_nxt.abEdges = s_r.abEdges + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.in1 <= 1'b1;
      s_r.filt <= 1'b1;
      s_r.rxF <= 1'b1;
      s_r.rxFd <= 1'b1;
      s_r.fcnt <= `LBAF_FCNT_RST;
      s_r.baud <= `LBAF_BAUD_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_addr_slot: assert property (s_r.rst == RX_DATA && s_r.bidx == 4'h7 && tick && rxOn |=>
    s_r.rst == ($past(s_r.mpMode) ? RX_ADDR : RX_STOP)) else $error("address slot misplaced");
  chk_stop_freeze: assert property (cpuStopped |=> s_r.lowBits == 4'h0 && s_r.rst == RX_IDLE)
    else $error("timing while stopped");
  chk_wake_len: assert property ($rose(s_r.wake) |-> $past(s_r.lowBits) >= `LBAF_WAKE_BITS)
    else $error("wake on short pulse");
  chk_break_sat: assert property (active && !fall && s_r.lowBits == `LBAF_BRK_SAT |=>
    s_r.lowBits == `LBAF_BRK_SAT) else $error("break count wrapped");
  chk_sleep_hold: assert property (s_r.lin.linLinkState == `LBAF_LS_SLEEP && !doWr |=>
    s_r.lin.linLinkState == `LBAF_LS_SLEEP) else $error("hardware left sleep");
  chk_break_flag: assert property ($rose(s_r.brk) |-> $past(s_r.lowBits) >= `LBAF_BRK_BITS
    && s_r.lin.linLinkState == `LBAF_LS_ABAUD) else $error("break flag wrong");
  chk_ab_prescale: assert property (s_r.lin.linLinkState == `LBAF_LS_ABAUD && s_r.abEdges != 3'h0
    && !abStep |=> $stable(s_r.abCnt)) else $error("autobaud count off prescale");
  chk_ab_load: assert property ($changed(s_r.baud) |-> $past(doWr) || ($past(s_r.lin.linLinkState)
    == `LBAF_LS_ABAUD && $past(s_r.lin.autobaudLoadEnable))) else $error("divider loaded wrongly");
  chk_ab_ovr: assert property ($rose(s_r.abOvr) |-> $stable(s_r.baud) && s_r.oe)
    else $error("overrun handling wrong");
  chk_filt_hyst: assert property ($fell(s_r.filt) |-> s_r.fcnt == 11'h0)
    else $error("filter fell unsaturated");
  chk_filt_delay: assert property ($fell(s_r.rxF) |-> $past(rxd, 3) == 1'b0)
    else $error("filter delay wrong");
  chk_noise_flag: assert property ($rose(s_r.ne) |-> $past(s_r.noisy || unsat))
    else $error("noise flag without noise");
  cov_break: cover property ($rose(s_r.brk));
  cov_wake: cover property ($rose(s_r.wake));
  cov_ab_load: cover property ($past(s_r.lin.linLinkState) == `LBAF_LS_ABAUD && $changed(s_r.baud));
  cov_char: cover property ($rose(s_r.rdy));
endmodule : lbaf_uart
`default_nettype wire

// ---- tb/lbaf_lin_node.sv ----
// bench partner: a lin / multiprocessor node driving the block's receive line
// assumes clk is the block clock; the line idles high, as its bus pull-up holds it
`timescale 1ns/1ps
`default_nettype none
module lbaf_lin_node (
  input wire logic clk,
  output logic rxd
);
  initial rxd = 1'b1;
  // ----------------------------------------
  // line driving, called just after a rising edge
  // ----------------------------------------
  task automatic hold_low(input int clks);
    rxd <= 1'b0;
    repeat (clks) @(posedge clk);
    rxd <= 1'b1;
  endtask : hold_low
  // lsb first; with nb 9 the flag bit sits after the data, before stop
  task automatic send_char(input logic [8:0] v, input int nb, input int bitClk);
    rxd <= 1'b0;
    repeat (bitClk) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      rxd <= v[i];
      repeat (bitClk) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (bitClk) @(posedge clk);
  endtask : send_char
  // all-zero char as wake request; bitClk 300 gives 270 us low, under 5 ms
  task automatic send_wake(input int bitClk);
    send_char(9'h000, 8, bitClk);
  endtask : send_wake
endmodule : lbaf_lin_node
`default_nettype wire

// ---- tb/lbaf_uart_tb.sv ----
// bench top: axi4-lite master tasks and one task per scenario
// assumes lbaf_uart and the lin node model; 10 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "lbaf_params.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin errors++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); end end
module lbaf_uart_tb import lbaf_pkg::*;;
  logic clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rxd, cpuStopped, rxFiltered;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, linLinkState;
  int errors, check_count, cycles;
  lbaf_uart DUT (.clk(clk), .nrst(nrst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rxd(rxd),
    .cpuStopped(cpuStopped), .rxFiltered(rxFiltered), .linLinkState(linLinkState));
  lbaf_lin_node node (.clk(clk), .rxd(rxd));
  always #50 clk = ~clk;
  // ----------------------------------------
  // closing and hang guard
  // ----------------------------------------
  task automatic end_sim();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      end_sim();
    end
  end
  // ----------------------------------------
  // bus tasks; each starts one edge on so no signal is driven twice at once
  // ----------------------------------------
  task automatic axw(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er, input logic [3:0] st = 4'hf);
    @(posedge clk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    s_axi_wstrb <= st;
    for (int n = 0; n < 50; n++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        `CHK(s_axi_bresp, er)
        break;
      end
    end
    s_axi_bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [5:0] a, input logic [1:0] er, output logic [31:0] d);
    @(posedge clk);
    d = 'x;
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        `CHK(s_axi_rresp, er)
        break;
      end
    end
    s_axi_rready <= 1'b0;
  endtask : axr
  task automatic rdchk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    axr(a, `LBAF_RESP_OK, rd);
    `CHK(rd & m, e)
  endtask : rdchk
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rdchk(`LBAF_A_BAUD, 32'hffff, 32'h10);
    `CHK(linLinkState, `LBAF_LS_SLEEP)
    axr(6'h18, `LBAF_RESP_ERR, rd);
    axw(`LBAF_A_MODESTAT, 32'h1, `LBAF_RESP_OK);
    axw(`LBAF_A_CTRL1, 32'h3, `LBAF_RESP_OK);
    axw(`LBAF_A_MODESTAT, 32'h0, `LBAF_RESP_OK);
    rdchk(`LBAF_A_CTRL1, 32'hff, 32'h0);
    axw(`LBAF_A_MODESTAT, 32'h1, `LBAF_RESP_OK);
    rdchk(`LBAF_A_CTRL1, 32'h7, 32'h3);
    axw(`LBAF_A_CTRL1, 32'h0, `LBAF_RESP_OK);
  endtask : t_reset
  // counter full at 4 then 5 bits: all-ones steps down, then the 3-clock delay
  task automatic t_filter();
    int n;
    for (int w = 0; w < 2; w++) begin
      axw(`LBAF_A_CTRL1, w, `LBAF_RESP_OK);
      repeat (40) @(posedge clk);
      n = 0;
      fork
        node.hold_low(56);
        while (rxFiltered === 1'b1 && n < 60) begin
          @(negedge clk);
          n++;
        end
      join
      `CHK(n inside {[17 + 16 * w:19 + 16 * w]}, 1'b1)
      repeat (60) @(posedge clk);
    end
    axw(`LBAF_A_CTRL1, 32'h0, `LBAF_RESP_OK);
  endtask : t_filter
  task automatic t_mp();
    axw(`LBAF_A_CTRL0, 32'h1, `LBAF_RESP_OK);
    axw(`LBAF_A_MODESTAT, 32'h0, `LBAF_RESP_OK);
    axw(`LBAF_A_CTRL1, 32'h1, `LBAF_RESP_OK);
    node.send_char(9'h1a5, 9, 16);
    repeat (40) @(posedge clk);
    rdchk(`LBAF_A_RXDATA, 32'h1ff, 32'h1a5);
    axw(`LBAF_A_CTRL1, 32'h0, `LBAF_RESP_OK);
  endtask : t_mp
  task automatic t_wake();
    axw(`LBAF_A_BAUD, 32'h5501, `LBAF_RESP_OK, 4'h1);
    rdchk(`LBAF_A_BAUD, 32'hffff, 32'h1);
    axw(`LBAF_A_BAUD, 32'h12c, `LBAF_RESP_OK);
    node.send_wake(300);
    repeat (40) @(posedge clk);
    rdchk(`LBAF_A_MODESTAT, 32'hf0, 32'h90);
    rdchk(`LBAF_A_STAT0, 32'h8, 32'h8);
    axr(`LBAF_A_RXDATA, `LBAF_RESP_OK, rd);
    axw(`LBAF_A_BAUD, 32'h10, `LBAF_RESP_OK);
    axw(`LBAF_A_STAT0, 32'h3e, `LBAF_RESP_OK);
    node.hold_low(32);
    repeat (200) @(posedge clk);
    rdchk(`LBAF_A_STAT0, 32'h8, 32'h0);
    node.hold_low(320);
    repeat (200) @(posedge clk);
    rdchk(`LBAF_A_MODESTAT, 32'hf0, 32'hf0);
    axr(`LBAF_A_RXDATA, `LBAF_RESP_OK, rd);
  endtask : t_wake
  // same pulse stopped and running: only the running cpu sees it
  task automatic t_stop(input logic stopped);
    axw(`LBAF_A_STAT0, 32'h3e, `LBAF_RESP_OK);
    cpuStopped <= stopped;
    node.hold_low(96);
    repeat (40) @(posedge clk);
    cpuStopped <= 1'b0;
    rdchk(`LBAF_A_STAT0, 32'h8, stopped ? 32'h0 : 32'h8);
  endtask : t_stop
  // first pass without load enable keeps the divider at 16 for the second
  task automatic t_slave();
    for (int ab = 0; ab < 2; ab++) begin
      axw(`LBAF_A_MODESTAT, 32'h2, `LBAF_RESP_OK);
      axw(`LBAF_A_CTRL1, 32'h9 | (ab << 2), `LBAF_RESP_OK);
      axw(`LBAF_A_MODESTAT, 32'h0, `LBAF_RESP_OK);
      axw(`LBAF_A_STAT0, 32'h3e, `LBAF_RESP_OK);
      `CHK(linLinkState, `LBAF_LS_WAIT)
      node.hold_low(128);
      repeat (40) @(posedge clk);
      rdchk(`LBAF_A_STAT0, 32'h10, 32'h0);
      node.hold_low(208);
      repeat (40) @(posedge clk);
      rdchk(`LBAF_A_STAT0, 32'h10, 32'h10);
      `CHK(linLinkState, `LBAF_LS_ABAUD)
      node.send_char(9'h055, 8, ab ? 96 : 64);
      repeat (60) @(posedge clk);
      `CHK(linLinkState, `LBAF_LS_ACTIVE)
      rdchk(`LBAF_A_BAUD, 32'hffff, ab ? 32'h60 : 32'h10);
      if (ab) rdchk(`LBAF_A_RXDATA, 32'hff, 32'h55);
      else axr(`LBAF_A_RXDATA, `LBAF_RESP_OK, rd);
    end
  endtask : t_slave
  initial begin
    clk = 1'b0; nrst = 1'b0; cpuStopped = 1'b0; s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0; s_axi_arvalid = 1'b0; s_axi_rready = 1'b0; s_axi_awaddr = 6'h00;
    s_axi_araddr = 6'h00; s_axi_wdata = 32'h0; s_axi_wstrb = 4'hf;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_filter();
    t_mp();
    t_wake();
    t_stop(1'b1);
    t_stop(1'b0);
    t_slave();
    end_sim();
  end
endmodule : lbaf_uart_tb
`default_nettype wire
